// ### cdr_mem_model.sv
// descriptor memory model answering the descriptor processor's fetch requests
`timescale 1ns/1ps
module cdr_mem_model
  import cdr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic desc_req,
  input wire logic [31:0] desc_addr,
  input wire logic [3:0] n_invalid,
  input wire logic [1:0] wait_cyc,
  output logic desc_ack,
  output cdr_desc_t desc_rsp,
  output logic [3:0] n_fetch
);
  logic [1:0] cnt_q;

  // the first n_invalid fetches since reset come back not yet valid
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
      desc_ack <= 1'b0;
      desc_rsp <= '0;
      n_fetch <= 4'h0;
    end else if (desc_req && !desc_ack && cnt_q >= wait_cyc) begin
      desc_ack <= 1'b1;
      cnt_q <= 2'h0;
      n_fetch <= n_fetch + 4'h1;
      desc_rsp.valid <= (n_fetch >= n_invalid);
      desc_rsp.next_ptr <= desc_addr + 32'h0000_0020;
    end else begin
      desc_ack <= 1'b0;
      cnt_q <= (desc_req && !desc_ack) ? cnt_q + 2'h1 : 2'h0;
      // released bus inverts every bit each cycle instead of holding the last answer
      desc_rsp <= ~desc_rsp;
    end
  end
endmodule : cdr_mem_model

// ### cdr_pkg.sv
// shared constants, types and helpers for the crypto dma control register bank
package cdr_pkg;
  localparam int unsigned DATA_W = 32;
  localparam logic [3:0] IDX_IDENT = 4'h0;
  localparam logic [3:0] IDX_CTRL = 4'h1;
  localparam logic [3:0] IDX_CUR_DESC = 4'h2;
  localparam logic [3:0] IDX_CHAIN_BASE = 4'h3;
  localparam logic [3:0] IDX_NONE = 4'hf;
  localparam int unsigned CTRL_OUT_SWAP_POS = 7;
  localparam int unsigned CTRL_SOFT_RST_POS = 6;
  localparam int unsigned CTRL_IN_SWAP_POS = 5;
  localparam int unsigned CTRL_FETCH_EN_POS = 2;
  localparam int unsigned CTRL_POLL_EN_POS = 1;
  localparam int unsigned CTRL_DMA_EN_POS = 0;
  localparam int unsigned ID_REV_LSB = 24;
  localparam int unsigned ID_VER_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CUR_DESC_RESET = 32'h0000_0000;
  localparam logic [31:0] CHAIN_BASE_RESET = 32'h0000_0000;
  localparam logic [3:0] STRB_FULL = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic out_swap;
    logic soft_rst;
    logic in_swap;
    logic fetch_en;
    logic poll_en;
    logic dma_en;
  } cdr_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [31:0] next_ptr;
  } cdr_desc_t;

  typedef enum logic [1:0] {
    CDR_IDLE = 2'h0,
    CDR_FETCH = 2'h1,
    CDR_ACTIVE = 2'h3
  } cdr_state_t;

  function automatic logic [31:0] cdr_bswap(input logic [31:0] w);
    cdr_bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : cdr_bswap

  function automatic logic [31:0] cdr_ctrl_word(input cdr_ctrl_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CTRL_OUT_SWAP_POS] = c.out_swap;
    w[CTRL_SOFT_RST_POS] = c.soft_rst;
    w[CTRL_IN_SWAP_POS] = c.in_swap;
    w[CTRL_FETCH_EN_POS] = c.fetch_en;
    w[CTRL_POLL_EN_POS] = c.poll_en;
    w[CTRL_DMA_EN_POS] = c.dma_en;
    cdr_ctrl_word = w;
  endfunction : cdr_ctrl_word
endpackage : cdr_pkg

// ### cdr_regs.sv
// crypto dma control registers, descriptor processor sequencing and data byte swapping
//
// Summary of operation
// RULE1: output swap bit reverses written word bytes
// RULE2: input swap bit reverses read word bytes
// RULE3: soft reset bit starts reset, self-clears
// RULE4: fetch enable bit gates descriptor fetching
// RULE5: poll enable re-reads descriptor until valid
// RULE6: software enables fetch/poll after descriptors written
// RULE7: dma enable bit turns transfer engine on
// RULE8: current descriptor address is read-only, resets zero
// RULE9: identification holds revision, version, code fields
// RULE10: unimplemented control bits read zero, ignore writes
// RULE11: only full 32-bit register accesses accepted
// RULE12: fetching starts at loaded chain base address
// RULE13: soft reset clears state before bit reads zero
`timescale 1ns/1ps
module cdr_regs
  import cdr_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter logic [7:0] ID_REVISION = 8'h01, // arbitrary value
  parameter logic [7:0] ID_VERSION = 8'h01, // arbitrary value
  parameter logic [15:0] ID_CODE = 16'h5a5a // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic desc_req,
  output logic [31:0] desc_addr,
  input wire logic desc_ack,
  input wire cdr_desc_t desc_rsp,
  input wire logic desc_done,
  input wire logic desc_last,
  input wire logic [31:0] desc_next_ptr,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_rvalid,
  output logic [31:0] eng_rdata,
  output logic eng_rvalid,
  input wire logic [31:0] eng_wdata,
  input wire logic eng_wvalid,
  output logic [31:0] mem_wdata,
  output logic mem_wvalid,
  output logic engine_reset,
  output logic dma_active
);

  function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] word;
    word = a >> 2;
    if (a[1:0] != 2'h0 || word > ADDR_W'(IDX_CHAIN_BASE)) begin
      reg_index = IDX_NONE;
    end else begin
      reg_index = word[3:0];
    end
  endfunction : reg_index

  cdr_ctrl_t ctrl_q;
  logic [31:0] chain_base_q;
  logic [31:0] cur_ptr_q;
  cdr_state_t state_q;
  logic started_q;
  logic aw_have_q, w_have_q;
  logic [3:0] aw_idx_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [3:0] rd_idx_q;
  logic wr_go;
  logic wr_full;
  logic wr_ctrl;
  logic start_go;

  // write channel: address and data may arrive in either order, response after both
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_full = (wstrb_q == STRB_FULL);
  assign wr_ctrl = wr_go && wr_full && aw_idx_q == IDX_CTRL; // RULE11
  assign start_go = state_q == CDR_IDLE && !started_q && ctrl_q.dma_en && ctrl_q.fetch_en && !ctrl_q.soft_rst;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      aw_idx_q <= IDX_NONE;
      s_axi_awready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= reg_index(s_axi_awaddr);
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      w_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (aw_idx_q == IDX_NONE) begin
        s_axi_bresp <= RESP_DECERR;
      end else if (!wr_full || aw_idx_q == IDX_IDENT || aw_idx_q == IDX_CUR_DESC) begin
        s_axi_bresp <= RESP_SLVERR; // RULE11 RULE8 RULE9
      end else begin
        s_axi_bresp <= RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control register: only bits 7..5 and 2..0 exist, the rest is never stored
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= cdr_ctrl_t'(6'h00); // RULE10
    end else if (ctrl_q.soft_rst) begin
      ctrl_q <= cdr_ctrl_t'(6'h00); // RULE3 RULE13
    end else if (wr_ctrl) begin
      ctrl_q.out_swap <= wdata_q[CTRL_OUT_SWAP_POS];
      ctrl_q.soft_rst <= wdata_q[CTRL_SOFT_RST_POS]; // RULE3
      ctrl_q.in_swap <= wdata_q[CTRL_IN_SWAP_POS];
      ctrl_q.fetch_en <= wdata_q[CTRL_FETCH_EN_POS];
      ctrl_q.poll_en <= wdata_q[CTRL_POLL_EN_POS];
      ctrl_q.dma_en <= wdata_q[CTRL_DMA_EN_POS];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chain_base_q <= CHAIN_BASE_RESET;
    end else if (wr_go && wr_full && aw_idx_q == IDX_CHAIN_BASE) begin
      chain_base_q <= wdata_q;
    end
  end

  // read channel: one word per request, answered the cycle after acceptance
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
      rd_idx_q <= IDX_NONE;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        rd_idx_q <= reg_index(s_axi_araddr);
        s_axi_rresp <= RESP_OKAY;
        unique case (reg_index(s_axi_araddr))
          IDX_IDENT: s_axi_rdata <= {ID_REVISION, ID_VERSION, ID_CODE}; // RULE9
          IDX_CTRL: s_axi_rdata <= cdr_ctrl_word(ctrl_q); // RULE10
          IDX_CUR_DESC: s_axi_rdata <= cur_ptr_q; // RULE8
          IDX_CHAIN_BASE: s_axi_rdata <= chain_base_q;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_DECERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // descriptor processor; dropping either enable parks it, a new start follows once both are high again
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CDR_IDLE;
      cur_ptr_q <= CUR_DESC_RESET;
      started_q <= 1'b0;
    end else if (ctrl_q.soft_rst) begin
      state_q <= CDR_IDLE; // RULE13
      cur_ptr_q <= CUR_DESC_RESET;
      started_q <= 1'b0;
    end else if (!ctrl_q.dma_en || !ctrl_q.fetch_en) begin
      state_q <= CDR_IDLE; // RULE4 RULE7
      started_q <= 1'b0;
    end else begin
      unique case (state_q)
        CDR_IDLE: begin
          if (start_go) begin
            state_q <= CDR_FETCH;
            cur_ptr_q <= chain_base_q; // RULE12
            started_q <= 1'b1;
          end
        end
        CDR_FETCH: begin
          if (desc_ack && desc_rsp.valid) begin
            state_q <= CDR_ACTIVE;
          end else if (desc_ack && !ctrl_q.poll_en) begin
            state_q <= CDR_IDLE; // RULE5
          end
        end
        CDR_ACTIVE: begin
          if (desc_done && desc_last) begin
            state_q <= CDR_IDLE;
          end else if (desc_done) begin
            state_q <= CDR_FETCH;
            cur_ptr_q <= desc_next_ptr;
          end
        end
        default: state_q <= CDR_IDLE;
      endcase
    end
  end

  // request is held until answered; with polling it stays raised after an invalid answer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      desc_req <= 1'b0;
      desc_addr <= 32'h0000_0000;
      dma_active <= 1'b0;
      engine_reset <= 1'b0;
    end else begin
      engine_reset <= wr_ctrl && wdata_q[CTRL_SOFT_RST_POS]; // RULE3
      dma_active <= state_q != CDR_IDLE && ctrl_q.dma_en && !ctrl_q.soft_rst;
      if (ctrl_q.soft_rst || !ctrl_q.dma_en || !ctrl_q.fetch_en) begin
        desc_req <= 1'b0; // RULE4
      end else if (start_go) begin
        desc_req <= 1'b1;
        desc_addr <= chain_base_q; // RULE12
      end else if (state_q == CDR_FETCH && desc_ack) begin
        desc_req <= !desc_rsp.valid && ctrl_q.poll_en; // RULE5
      end else if (state_q == CDR_ACTIVE && desc_done && !desc_last) begin
        desc_req <= 1'b1;
        desc_addr <= desc_next_ptr;
      end
    end
  end

  // data words are registered once in each direction, byte swapped when that direction's swap bit is set
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      eng_rdata <= 32'h0000_0000;
      eng_rvalid <= 1'b0;
      mem_wdata <= 32'h0000_0000;
      mem_wvalid <= 1'b0;
    end else begin
      eng_rvalid <= mem_rvalid && ctrl_q.dma_en; // RULE7
      eng_rdata <= ctrl_q.in_swap ? cdr_bswap(mem_rdata) : mem_rdata; // RULE2
      mem_wvalid <= eng_wvalid && ctrl_q.dma_en; // RULE7
      mem_wdata <= ctrl_q.out_swap ? cdr_bswap(eng_wdata) : eng_wdata; // RULE1
    end
  end

  a_out_swap: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE1
    ctrl_q.out_swap && !wr_ctrl |=> mem_wdata == cdr_bswap($past(eng_wdata)))
    else $error("output word not byte swapped");
  a_in_plain: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
    !ctrl_q.in_swap && !wr_ctrl ##1 mem_rvalid |=> eng_rdata == $past(mem_rdata))
    else $error("input word altered with swap off");
  a_soft_rst_clear: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE3
    wr_ctrl && wdata_q[CTRL_SOFT_RST_POS] |=> ctrl_q.soft_rst && engine_reset ##1 !ctrl_q.soft_rst)
    else $error("soft reset bit not set then self cleared");
  a_fetch_gate: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
    !ctrl_q.fetch_en |=> !desc_req && state_q == CDR_IDLE)
    else $error("descriptor fetch with fetch disabled");
  a_poll_retry: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
    state_q == CDR_FETCH && desc_ack && !desc_rsp.valid && ctrl_q.poll_en && ctrl_q.dma_en && ctrl_q.fetch_en
    && !ctrl_q.soft_rst |=> state_q == CDR_FETCH && desc_req && desc_addr == $past(desc_addr))
    else $error("invalid descriptor not polled again");
  a_dma_off: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
    !ctrl_q.dma_en |=> !mem_wvalid && !eng_rvalid && !dma_active)
    else $error("transfer with dma disabled");
  a_cur_ro: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
    wr_go && aw_idx_q == IDX_CUR_DESC |=> s_axi_bresp == RESP_SLVERR && $stable(cur_ptr_q))
    else $error("current descriptor address written");
  a_ident_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE9
    s_axi_arvalid && s_axi_arready && reg_index(s_axi_araddr) == IDX_IDENT
    |=> s_axi_rvalid && s_axi_rdata == {ID_REVISION, ID_VERSION, ID_CODE})
    else $error("identification word wrong");
  a_ctrl_unimpl: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE10
    s_axi_rvalid && rd_idx_q == IDX_CTRL |-> s_axi_rdata[31:8] == 24'h000000 && s_axi_rdata[4:3] == 2'h0)
    else $error("unimplemented control bits read nonzero");
  a_partial_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE11
    wr_go && !wr_full |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR && ctrl_q == $past(ctrl_q))
    else $error("partial write not refused");
  a_first_desc: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE12
    start_go |=> desc_req && desc_addr == $past(chain_base_q) && cur_ptr_q == $past(chain_base_q))
    else $error("fetch not started at chain base");
  a_rst_state: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE13
    ctrl_q.soft_rst |=> !ctrl_q.soft_rst && state_q == CDR_IDLE && cur_ptr_q == CUR_DESC_RESET && !ctrl_q.dma_en)
    else $error("soft reset left state behind");
  // the swap paths are checked in both settings so a stuck select cannot hide
  a_in_swap: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
    ctrl_q.in_swap |=> eng_rdata == cdr_bswap($past(mem_rdata)))
    else $error("input word not byte swapped");
  a_out_plain: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE1
    !ctrl_q.out_swap |=> mem_wdata == $past(eng_wdata))
    else $error("output word altered with swap off");
  a_rst_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE3
    engine_reset |=> !engine_reset)
    else $error("engine reset longer than one cycle");
  a_poll_stop: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
    state_q == CDR_FETCH && desc_ack && !desc_rsp.valid && !ctrl_q.poll_en
    |=> !desc_req && state_q == CDR_IDLE)
    else $error("invalid descriptor re-read with polling off");
  a_chain_next: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
    state_q == CDR_ACTIVE && desc_done && !desc_last && ctrl_q.dma_en && ctrl_q.fetch_en && !ctrl_q.soft_rst
    |=> desc_req && cur_ptr_q == $past(desc_next_ptr) && desc_addr == $past(desc_next_ptr))
    else $error("current descriptor address not advanced");
  a_dma_pass: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
    ctrl_q.dma_en && eng_wvalid |=> mem_wvalid)
    else $error("output word dropped with dma enabled");

  c_poll_loop: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == CDR_FETCH && desc_ack && !desc_rsp.valid ##1 state_q == CDR_FETCH);
  c_soft_rst: cover property (@(posedge clk_sys) disable iff (!rst_n) engine_reset);
  c_chain_next: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == CDR_ACTIVE && desc_done && !desc_last);
  c_swapped_write: cover property (@(posedge clk_sys) disable iff (!rst_n) mem_wvalid && ctrl_q.out_swap);
  c_poll_stop: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == CDR_FETCH && desc_ack && !desc_rsp.valid && !ctrl_q.poll_en);

endmodule : cdr_regs

// ### testbench.sv
// self-checking bench for the crypto dma control register bank
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  import cdr_pkg::*;
  localparam logic [7:0] REV = 8'h3c; // arbitrary value
  localparam logic [7:0] VER = 8'h07; // arbitrary value
  localparam logic [15:0] IDC = 16'hc0de; // arbitrary value
  localparam logic [31:0] ID_WORD = {REV, VER, IDC};
  logic clk_sys = 1'b0, rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, desc_addr, desc_next_ptr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0, n_invalid = 4'h0, n_fetch;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, desc_req, desc_ack;
  logic [1:0] s_axi_bresp, s_axi_rresp, wait_cyc = 2'h0;
  cdr_desc_t desc_rsp;
  logic desc_done = 1'b0, desc_last = 1'b0, mem_rvalid = 1'b0, eng_wvalid = 1'b0;
  logic [31:0] mem_rdata = 32'h0, eng_wdata = 32'h0, eng_rdata, mem_wdata;
  logic eng_rvalid, mem_wvalid, engine_reset, dma_active;
  int err_count = 0, n_compared = 0, cycles = 0, n_rst = 0, k;

  cdr_regs #(.ID_REVISION(REV), .ID_VERSION(VER), .ID_CODE(IDC)) cdr_regs_inst (.clk_sys, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .desc_req, .desc_addr, .desc_ack, .desc_rsp, .desc_done, .desc_last,
    .desc_next_ptr, .mem_rdata, .mem_rvalid, .eng_rdata, .eng_rvalid, .eng_wdata, .eng_wvalid, .mem_wdata,
    .mem_wvalid, .engine_reset, .dma_active);
  cdr_mem_model cdr_mem_model_inst (.clk_sys, .rst_n, .desc_req, .desc_addr, .n_invalid, .wait_cyc, .desc_ack,
    .desc_rsp, .n_fetch);

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (engine_reset === 1'b1) n_rst++;
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic do_reset(input logic [3:0] ni, input logic [1:0] wc);
    n_invalid <= ni;
    wait_cyc <= wc;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1 && !aw_ok) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_ok) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
    @(posedge clk_sys);
  endtask : rd

  // one word each way through the swap paths
  task automatic dchk(input logic [31:0] ei, input logic [31:0] eo, input logic ev);
    mem_rdata <= 32'h1122_3344;
    eng_wdata <= 32'ha1b2_c3d4;
    mem_rvalid <= 1'b1;
    eng_wvalid <= 1'b1;
    @(posedge clk_sys);
    mem_rvalid <= 1'b0;
    eng_wvalid <= 1'b0;
    @(posedge clk_sys);
    `CHK(eng_rvalid, ev)
    `CHK(mem_wvalid, ev)
    if (ev) begin
      `CHK(eng_rdata, ei)
      `CHK(mem_wdata, eo)
    end
  endtask : dchk

  task automatic wt(input logic [3:0] nf, input logic act);
    k = 0;
    while ((n_fetch !== nf || dma_active !== act) && k < 60) begin
      @(posedge clk_sys);
      k++;
    end
    `CHK(n_fetch, nf)
    `CHK(dma_active, act)
  endtask : wt

  task automatic endtest(input string s);
    $display("test %s done: %0d compared, %0d wrong", s, n_compared, err_count);
  endtask : endtest

  initial begin
    do_reset(4'h2, 2'h2);
    rd(8'h00, ID_WORD, RESP_OKAY);
    rd(8'h04, 32'h0, RESP_OKAY);
    rd(8'h08, 32'h0, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_DECERR);
    wr(8'h0c, 32'h0000_1000, STRB_FULL, RESP_OKAY);
    wr(8'h04, 32'hffff_ffbf, STRB_FULL, RESP_OKAY);
    rd(8'h04, 32'h0000_00a7, RESP_OKAY);
    wt(4'h3, 1'b1);
    rd(8'h08, 32'h0000_1000, RESP_OKAY);
    `CHK(desc_addr, 32'h0000_1000)
    `CHK(desc_req, 1'b0)
    dchk(32'h4433_2211, 32'hd4c3_b2a1, 1'b1);
    wr(8'h00, 32'hffff_ffff, STRB_FULL, RESP_SLVERR);
    wr(8'h08, 32'hffff_ffff, STRB_FULL, RESP_SLVERR);
    wr(8'h04, 32'h0, 4'h3, RESP_SLVERR);
    rd(8'h04, 32'h0000_00a7, RESP_OKAY);
    rd(8'h00, ID_WORD, RESP_OKAY);
    desc_next_ptr <= 32'h0000_2000;
    desc_done <= 1'b1;
    @(posedge clk_sys);
    desc_done <= 1'b0;
    wt(4'h4, 1'b1);
    rd(8'h08, 32'h0000_2000, RESP_OKAY);
    `CHK(desc_addr, 32'h0000_2000)
    endtest("chain");
    wr(8'h04, 32'h0000_0040, STRB_FULL, RESP_OKAY);
    `CHK(n_rst, 1)
    rd(8'h04, 32'h0, RESP_OKAY);
    rd(8'h08, 32'h0, RESP_OKAY);
    `CHK(dma_active, 1'b0)
    rd(8'h0c, 32'h0000_1000, RESP_OKAY);
    endtest("soft_reset");
    do_reset(4'h1, 2'h0);
    wr(8'h04, 32'h0000_0005, STRB_FULL, RESP_OKAY);
    wt(4'h1, 1'b0);
    dchk(32'h1122_3344, 32'ha1b2_c3d4, 1'b1);
    `CHK(n_fetch, 4'h1)
    `CHK(desc_req, 1'b0)
    wr(8'h04, 32'h0000_0001, STRB_FULL, RESP_OKAY);
    dchk(32'h1122_3344, 32'ha1b2_c3d4, 1'b1);
    `CHK(n_fetch, 4'h1)
    wr(8'h04, 32'h0000_0004, STRB_FULL, RESP_OKAY);
    dchk(32'h0, 32'h0, 1'b0);
    `CHK(n_fetch, 4'h1)
    wr(8'h04, 32'h0000_0005, STRB_FULL, RESP_OKAY);
    wt(4'h2, 1'b1);
    endtest("enables");
    conclude();
  end
endmodule : testbench
